//--- design/ptc_paired_timer.v
`include "ptc_regs.vh"
`default_nettype none
// Function
// - Gate setting is ignored when the external clock is selected.
// - Internal clock with gate set accumulates under gate; zero disables gating.
// - Prescale 11=1:256, 10=1:64, 01=1:8, 00=1:1.
// - Pair bit set joins lower and upper counters into one 32-bit counter.
// - Pair bit clear gives two independent 16-bit timers, own controls.
// - Clock source one uses external pin, zero uses internal half clock.
// - In pair mode idle behaviour follows the even timer's idle halt.
// - In pair mode odd run, gate, prescale, source bits have no effect.
// - Unimplemented control bits read zero and ignore writes.
// - Even register has pair bit; odd register lacks it, forms upper half.
// - In 16-bit mode run bit starts and stops that timer.
// - In pair mode even run bit starts and stops the pair.
module ptc_paired_timer (
  input  wire        mclk,       // 250 MHz system clock
  input  wire        reset_n,    // Async reset, active low
  input  wire        wb_cyc_i,   // Wishbone cycle
  input  wire        wb_stb_i,   // Wishbone strobe
  input  wire        wb_we_i,    // Wishbone write enable
  input  wire [7:0]  wb_adr_i,   // Wishbone byte address
  input  wire [3:0]  wb_sel_i,   // Wishbone byte selects
  input  wire [31:0] wb_dat_i,   // Wishbone write data
  output reg  [31:0] wb_dat_o,   // Wishbone read data
  output reg         wb_ack_o,   // Wishbone acknowledge
  output reg         wb_err_o,   // Wishbone error, unmapped address
  input  wire        evenPin,    // External clock/gate pin, even timer
  input  wire        oddPin,     // External clock/gate pin, odd timer
  output reg         pairWide    // Pair mode in force
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  reg  [15:0] evenCtrl;
  reg  [15:0] oddCtrl;
  reg  [15:0] lowerCounter;
  reg  [15:0] upperCounter;
  reg         idleMode;
  reg         intDiv;
  reg  [1:0]  evenSync;
  reg  [1:0]  oddSync;
  reg         evenLast;
  reg         oddLast;
  wire        evenRise;
  wire        oddRise;
  wire        evenTick;
  wire        oddTick;
  wire        pair;
  wire        wbReq;
  wire        wrEn;
  wire        wrEvenCtrl;
  wire        wrOddCtrl;
  wire        wrLower;
  wire        wrUpper;
  wire        wrIdle;
  wire        lowerWrap;
  wire        upperStep;
  wire [1:0]  runVec;
  wire [1:0]  idleHaltVec;
  wire [1:0]  gateVec;
  wire [3:0]  psVec;
  wire [1:0]  clkSrcVec;
  wire [1:0]  riseVec;
  wire [1:0]  levelVec;
  wire [1:0]  tickVec;
  reg  [15:0] readWord;

  assign pair     = evenCtrl[`PTC_BIT_PAIR];
  assign wbReq    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wrEn     = wbReq & wb_we_i;
  assign evenRise = evenSync[1] & ~evenLast;
  assign oddRise  = oddSync[1] & ~oddLast;

  // Merge byte lanes 0 and 1 into the old value
  function [15:0] ptcMerge;
    input [15:0] oldVal;
    input [31:0] newVal;
    input [3:0]  sel;
    begin
      ptcMerge[7:0]  = sel[0] ? newVal[7:0]  : oldVal[7:0];
      ptcMerge[15:8] = sel[1] ? newVal[15:8] : oldVal[15:8];
    end
  endfunction

  // Known register address
  function ptcMapped;
    input [7:0] adr;
    begin
      ptcMapped = (adr == `PTC_ADDR_EVEN_CTRL) | (adr == `PTC_ADDR_ODD_CTRL) |
                  (adr == `PTC_ADDR_LOWER_CNT) | (adr == `PTC_ADDR_UPPER_CNT) |
                  (adr == `PTC_ADDR_IDLE);
    end
  endfunction

  // Exact match of a request address against one register
  function ptcHit;
    input [7:0] adr;
    input [7:0] target;
    begin
      ptcHit = (adr == target);
    end
  endfunction

  // ---------------------------------------------------------------
  // Write strobes
  // ---------------------------------------------------------------
  // One strobe per register, all taken on the request edge
  assign wrEvenCtrl = wrEn & ptcHit(wb_adr_i, `PTC_ADDR_EVEN_CTRL);
  assign wrOddCtrl  = wrEn & ptcHit(wb_adr_i, `PTC_ADDR_ODD_CTRL);
  assign wrLower    = wrEn & ptcHit(wb_adr_i, `PTC_ADDR_LOWER_CNT);
  assign wrUpper    = wrEn & ptcHit(wb_adr_i, `PTC_ADDR_UPPER_CNT);
  // Idle flag lives in lane 0 only
  assign wrIdle     = wrEn & ptcHit(wb_adr_i, `PTC_ADDR_IDLE) & wb_sel_i[0];

  // ---------------------------------------------------------------
  // Pin synchronisers and internal clock divider
  // ---------------------------------------------------------------
  // Two flops per pin; the edge detector reads only the second
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      evenSync <= 2'b00;
      oddSync  <= 2'b00;
      evenLast <= 1'b0;
      oddLast  <= 1'b0;
    end else begin
      evenSync <= {evenSync[0], evenPin};
      oddSync  <= {oddSync[0], oddPin};
      evenLast <= evenSync[1];
      oddLast  <= oddSync[1];
    end
  end

  // Half-rate enable; one pulse every second cycle stands in for the
  // internal instruction clock, so no second clock domain is needed
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      intDiv <= 1'b0;
    end else begin
      intDiv <= ~intDiv;
    end
  end

  // ---------------------------------------------------------------
  // Tick generators
  // ---------------------------------------------------------------
  // Index 0 is the even (lower) timer, index 1 the odd (upper) one
  // In pair mode the odd run bit is masked, so its path stays idle
  assign runVec      = {oddCtrl[`PTC_BIT_RUN] & ~pair,
                        evenCtrl[`PTC_BIT_RUN]};
  assign idleHaltVec = {oddCtrl[`PTC_BIT_IDLE_HALT],
                        evenCtrl[`PTC_BIT_IDLE_HALT]};
  assign gateVec     = {oddCtrl[`PTC_BIT_GATE], evenCtrl[`PTC_BIT_GATE]};
  assign psVec       = {oddCtrl[`PTC_BIT_PS_HI:`PTC_BIT_PS_LO],
                        evenCtrl[`PTC_BIT_PS_HI:`PTC_BIT_PS_LO]};
  assign clkSrcVec   = {oddCtrl[`PTC_BIT_CLK_SRC], evenCtrl[`PTC_BIT_CLK_SRC]};
  assign riseVec     = {oddRise, evenRise};
  assign levelVec    = {oddSync[1], evenSync[1]};
  assign evenTick    = tickVec[0];
  assign oddTick     = tickVec[1];

  // Same tick logic for both timers
  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1) begin : gTick
      ptc_tick_gen uTick (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .run      (runVec[t]),
        .idleHalt (idleHaltVec[t]),
        .idleMode (idleMode),
        .gateEn   (gateVec[t]),
        .psSel    (psVec[2*t+1:2*t]),
        .clkSrc   (clkSrcVec[t]),
        .intTick  (intDiv),
        .extRise  (riseVec[t]),
        .pinLevel (levelVec[t]),
        .tick     (tickVec[t])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------
  // Carry out of the lower half feeds the upper half in pair mode
  assign lowerWrap = evenTick & (lowerCounter == 16'hFFFF);
  // Odd controls are bypassed in pair mode; only the carry counts
  assign upperStep = pair ? lowerWrap : oddTick;

  // Lower counter; a bus write beats a tick in the same cycle
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lowerCounter <= 16'h0000;
    end else if (wrLower) begin
      lowerCounter <= ptcMerge(lowerCounter, wb_dat_i, wb_sel_i);
    end else if (evenTick) begin
      lowerCounter <= lowerCounter + 16'h0001;
    end
  end

  // Upper counter; same write priority, so software can preload it
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      upperCounter <= 16'h0000;
    end else if (wrUpper) begin
      upperCounter <= ptcMerge(upperCounter, wb_dat_i, wb_sel_i);
    end else if (upperStep) begin
      upperCounter <= upperCounter + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Even control; the mask drops unimplemented bits so they never store
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      evenCtrl <= `PTC_CTRL_RESET;
    end else if (wrEvenCtrl) begin
      evenCtrl <= ptcMerge(evenCtrl, wb_dat_i, wb_sel_i) & `PTC_EVEN_MASK;
    end
  end

  // Odd control; its mask has no pair bit, so pairing is even-side only
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      oddCtrl <= `PTC_CTRL_RESET;
    end else if (wrOddCtrl) begin
      oddCtrl <= ptcMerge(oddCtrl, wb_dat_i, wb_sel_i) & `PTC_ODD_MASK;
    end
  end

  // Idle stand-in; software sets it where a power manager would
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      idleMode <= 1'b0;
    end else if (wrIdle) begin
      idleMode <= wb_dat_i[0];
    end
  end

  // Pair flag output, one cycle behind the control bit
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pairWide <= 1'b0;
    end else begin
      pairWide <= pair;
    end
  end

  // ---------------------------------------------------------------
  // Wishbone answer
  // ---------------------------------------------------------------
  // Read mux; the upper half of every word reads zero
  always @* begin
    readWord = 16'h0000;
    case (wb_adr_i)
      `PTC_ADDR_EVEN_CTRL: readWord = evenCtrl;
      `PTC_ADDR_ODD_CTRL:  readWord = oddCtrl;
      `PTC_ADDR_LOWER_CNT: readWord = lowerCounter;
      `PTC_ADDR_UPPER_CNT: readWord = upperCounter;
      `PTC_ADDR_IDLE:      readWord = {15'h0000, idleMode};
      default:             readWord = 16'h0000;
    endcase
  end

  // One wait state; ack or err drops the cycle after it rises
  // Data is zero outside a read answer so stale values never leak
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbReq & ptcMapped(wb_adr_i);
      wb_err_o <= wbReq & ~ptcMapped(wb_adr_i);
      if (wbReq && !wb_we_i) begin
        wb_dat_o <= {16'h0000, readWord};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end
endmodule
`default_nettype wire

//--- design/ptc_regs.vh
`ifndef PTC_REGS_VH
`define PTC_REGS_VH
// ---------------------------------------------------------------
// Register map (byte addresses, one 32-bit word each)
// ---------------------------------------------------------------
`define PTC_ADDR_EVEN_CTRL   8'h00
`define PTC_ADDR_ODD_CTRL    8'h04
`define PTC_ADDR_LOWER_CNT   8'h08
`define PTC_ADDR_UPPER_CNT   8'h0C
`define PTC_ADDR_IDLE        8'h10
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PTC_BIT_RUN          15
`define PTC_BIT_IDLE_HALT    13
`define PTC_BIT_GATE         6
`define PTC_BIT_PS_HI        5
`define PTC_BIT_PS_LO        4
`define PTC_BIT_PAIR         3
`define PTC_BIT_CLK_SRC      1
// Writable masks; every other bit reads zero
`define PTC_EVEN_MASK        16'hA07A
`define PTC_ODD_MASK         16'hA072
// ---------------------------------------------------------------
// Reset values and prescale counts
// ---------------------------------------------------------------
`define PTC_CTRL_RESET       16'h0000
`define PTC_PS_DIV8          8'h07
`define PTC_PS_DIV64         8'h3F
`define PTC_PS_DIV256        8'hFF
`endif

//--- design/ptc_tick_gen.v
`include "ptc_regs.vh"
`default_nettype none
// Turns one timer's control bits into a one-cycle count pulse
module ptc_tick_gen (
  input  wire       mclk,       // System clock
  input  wire       reset_n,    // Async reset, active low
  input  wire       run,        // Timer enable
  input  wire       idleHalt,   // Stop while idle
  input  wire       idleMode,   // Device idle
  input  wire       gateEn,     // Gated accumulation
  input  wire [1:0] psSel,      // Prescale select
  input  wire       clkSrc,     // 1 = external pin
  input  wire       intTick,    // Internal clock enable
  input  wire       extRise,    // Synced pin rising edge
  input  wire       pinLevel,   // Synced pin level
  output reg        tick        // Count pulse
);
  reg  [7:0] psCount;
  reg  [7:0] psLimit;
  wire       srcEdge;
  wire       active;

  // ---------------------------------------------------------------
  // Source selection and gating
  // ---------------------------------------------------------------
  // Gate only matters on the internal clock; external ignores it
  assign srcEdge = clkSrc ? extRise :
                   (intTick & (~gateEn | pinLevel));
  assign active  = run & ~(idleHalt & idleMode);

  // Prescale terminal count
  always @* begin
    case (psSel)
      2'b11:   psLimit = `PTC_PS_DIV256;
      2'b10:   psLimit = `PTC_PS_DIV64;
      2'b01:   psLimit = `PTC_PS_DIV8;
      default: psLimit = 8'h00;
    endcase
  end

  // Prescaler; cleared when stopped so restarts are aligned
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      psCount <= 8'h00;
      tick    <= 1'b0;
    end else if (!active) begin
      psCount <= 8'h00;
      tick    <= 1'b0;
    end else if (srcEdge) begin
      if (psCount >= psLimit) begin
        psCount <= 8'h00;
        tick    <= 1'b1;
      end else begin
        psCount <= psCount + 8'h01;
        tick    <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- test/ptc_paired_timer_chk.sv
`include "ptc_regs.vh"
`default_nettype none
// ------
// Port checker
// ------
module ptc_paired_timer_chk (
  input wire logic        mclk,      // Clock
  input wire logic        reset_n,   // Reset, active low
  input wire logic        wb_cyc_i,  // Cycle
  input wire logic        wb_stb_i,  // Strobe
  input wire logic        wb_we_i,   // Write
  input wire logic [7:0]  wb_adr_i,  // Address
  input wire logic [3:0]  wb_sel_i,  // Selects
  input wire logic [31:0] wb_dat_i,  // Write data
  input wire logic [31:0] wb_dat_o,  // Read data
  input wire logic        wb_ack_o,  // Ack
  input wire logic        wb_err_o,  // Error
  input wire logic        pairWide   // Pair in force
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Request taken only when no answer is pending
  wire taken = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire mapped = wb_adr_i == 8'h00 || wb_adr_i == 8'h04 || wb_adr_i == 8'h08
    || wb_adr_i == 8'h0C || wb_adr_i == 8'h10;
  wire wrEven = taken & wb_we_i & wb_sel_i[0] & (wb_adr_i == 8'h00);
  AST_ACK_MAP: assert property (taken && mapped |=> wb_ack_o && !wb_err_o)
    else $error("mapped request not acked");
  AST_ERR_UNMAP: assert property (taken && !mapped |=> wb_err_o && !wb_ack_o)
    else $error("unmapped request not refused");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data without ack");
  AST_EVEN_RSV: assert property (wb_ack_o && $past(wb_adr_i) == 8'h00 |->
    (wb_dat_o & ~{16'h0, `PTC_EVEN_MASK}) == 32'h0) else $error("even spare bits set");
  AST_ODD_RSV: assert property (wb_ack_o && $past(wb_adr_i) == 8'h04 |->
    (wb_dat_o & ~{16'h0, `PTC_ODD_MASK}) == 32'h0) else $error("odd spare bits set");
  AST_PAIR_WR: assert property (wrEven |=> ##1 pairWide == $past(wb_dat_i[3], 2))
    else $error("pair mode does not follow write");
  AST_PAIR_HOLD: assert property ($changed(pairWide) |-> $past(wrEven, 2))
    else $error("pair mode changed without write");
  AST_RST_ZERO: assert property ($rose(reset_n) |-> !pairWide && !wb_ack_o)
    else $error("not idle after reset");
endmodule
bind ptc_paired_timer ptc_paired_timer_chk ptc_paired_timer_chk_i (.mclk(mclk),
  .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .pairWide(pairWide));
`default_nettype wire

//--- test/ptc_paired_timer_test.sv
`default_nettype none
// ------
// Testbench
// ------
module ptc_paired_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset_n, wbCyc, wbStb, wbWe, wbAck, wbErr, pairWide;
  logic evenPin, clkRun, gateLvl, errSeen;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatI, wbDatO, q;
  int num_errors, samples_checked, i;
  int divs[4] = '{1, 8, 64, 256};
  ptc_paired_timer ptc_paired_timer_i (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .wb_err_o(wbErr),
    .evenPin(evenPin), .oddPin(evenPin), .pairWide(pairWide)); // One pin model feeds both
  ptc_pin_model ptc_pin_model_i (.mclk(mclk), .clkRun(clkRun), .gateLvl(gateLvl),
    .pin(evenPin));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Start-up and stop latency make counts fuzzy by a tick or two
  task automatic chkIn(string n, int lo, int hi, logic [31:0] g);
    samples_checked++;
    if ($isunknown(g) || !(g >= lo && g <= hi)) begin
      num_errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  // One classic cycle; held until ack or err is sampled
  task automatic wb(logic [7:0] a, logic w, logic [31:0] d, output logic [31:0] r,
                    output logic e);
    int n;
    @(posedge mclk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatI, wbSel} <= {2'b11, w, a, d, 4'h3};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!(wbAck || wbErr) && n < 50);
    r = wbDatO;
    e = wbErr;
    {wbCyc, wbStb} <= 2'b00;
    if (n >= 50) chk("bus answer", 1, 0);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic e;
    wb(a, 1'b1, d, q, e);
  endtask
  task automatic rd(logic [7:0] a, string n, logic [31:0] x);
    logic e;
    wb(a, 1'b0, 32'h0, q, e);
    chk(n, x, q);
  endtask
  // Clear, run for a span, stop, then read the count
  task automatic runCnt(logic [7:0] ca, logic [15:0] ctl, int cyc, int ex, int tol);
    logic [7:0] na;
    logic       e;
    na = (ca == 8'h00) ? 8'h08 : 8'h0C;
    wr(na, 32'h0);
    wr(ca, {16'h0, ctl});
    repeat (cyc) @(posedge mclk);
    wr(ca, 32'h0);
    wr(8'h04, 32'h0);
    wb(na, 1'b0, 32'h0, q, e);
    chk("count read err", 0, {31'h0, e});
    chkIn("count", ex - tol, ex + tol, q);
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Watchdog sized well above the longest prescale run
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    {reset_n, wbCyc, wbStb, wbWe, clkRun, gateLvl} = 6'h0;
    {wbAdr, wbSel, wbDatI} = 44'h0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    rd(8'h00, "even reset", 32'h0);
    rd(8'h04, "odd reset", 32'h0);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, "even spare", 32'h0000A07A);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, "odd spare", 32'h0000A072);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    wb(8'h14, 1'b0, 32'h0, q, errSeen);
    chk("unmapped err", 1, {31'h0, errSeen});
    for (i = 0; i < 4; i++)
      runCnt(8'h00, 16'h8000 | (i << 4), 64 * divs[i], 32, 2);
    runCnt(8'h04, 16'h8000, 64, 32, 2);
    runCnt(8'h00, 16'h8040, 64, 0, 0);
    gateLvl <= 1'b1;
    runCnt(8'h00, 16'h8040, 64, 32, 2);
    clkRun <= 1'b1;
    runCnt(8'h00, 16'h8042, 160, 20, 2);
    runCnt(8'h04, 16'h8002, 160, 20, 2);
    wr(8'h10, 32'h1);
    runCnt(8'h00, 16'hA000, 64, 0, 0);
    runCnt(8'h00, 16'h8000, 64, 32, 2);
    runCnt(8'h00, 16'hA008, 64, 0, 0);
    wr(8'h10, 32'h0);
    wr(8'h08, 32'h0000FFFF);
    wr(8'h0C, 32'h0);
    wr(8'h04, 32'h00008032);
    wr(8'h00, 32'h00008008);
    repeat (20) @(posedge mclk);
    chk("pair flag", 1, {31'h0, pairWide});
    wr(8'h00, 32'h0);
    rd(8'h0C, "upper carry", 32'h1);
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- test/ptc_pin_model.sv
`default_nettype none
// ------
// Far-side pin: external clock or gate level
// ------
module ptc_pin_model (
  input  wire logic mclk,     // System clock
  input  wire logic clkRun,   // Toggle as a clock
  input  wire logic gateLvl,  // Level when not clocking
  output var  logic pin       // Pin to the timer
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase;
  // Eight-cycle period keeps edges well apart from the sync delay
  always @(posedge mclk) begin
    phase <= phase + 2'h1;
    if (!clkRun)
      pin <= gateLvl;
    else if (phase == 2'h3)
      pin <= ~pin;
  end
  initial begin
    phase = 2'h0;
    pin = 1'b0;
  end
endmodule
`default_nettype wire
